// ===== pkg/vcp_pkg.sv
// Constants, register map and state encodings for the voice codec control block.
// Assumes a 250 MHz hclk; every register is one aligned 32-bit word on AHB-Lite.
// Function
// - Reset loads every control register default
// - Registers writable while powered down
// - Power bit 1 picks differential or single-ended earpiece
// - Power bit 0 clear powers down; gain bit7 depth
// - Master clock loss forces power-down
// - Clock-loss power-down floats serial transmit output
// - Power-down waits for current sample to finish
// - Gain bit 7 makes power-down ignore clock detector
// - Linear 15-bit or companded 8-bit sample format
// - Approximate mu-law/A-law; linear is two's complement
// - Power bit 6 mutes the microphone
// - Codes 0000-0101 extended mode, second stage on
// - Codes 1000-1101 normal mode, second stage off
// - Gain code resets to 1000 (23.5 dB)
// - Frame sync sampled on bit clock falling edge
// - Receive data captured on bit clock falling edge
// - Transmit bits launched on bit clock rising edge
// - Output floats after last bit's falling edge
// - Samples travel most significant bit first
package vcp_pkg;

    // Register byte offsets
    localparam logic [7:0] VCP_OFS_POWER   = 8'h00;  // Power control
    localparam logic [7:0] VCP_OFS_TXGAIN  = 8'h04;  // Transmit gain / sidetone
    localparam logic [7:0] VCP_OFS_FORMAT  = 8'h08;  // Sample format
    localparam logic [7:0] VCP_OFS_STATUS  = 8'h0C;  // Read-only state
    localparam logic [7:0] VCP_OFS_RXDATA  = 8'h10;  // Last received sample

    // Power control fields
    localparam int VCP_PWR_ON_BIT   = 0;  // 1 = powered up
    localparam int VCP_PWR_EAR_BIT  = 1;  // 1 = differential earpiece
    localparam int VCP_PWR_MUTE_BIT = 6;  // 1 = microphone muted
    localparam int VCP_PWR_W        = 8;  // Implemented width

    // Transmit gain fields
    localparam int VCP_TXG_CODE_MSB = 3;  // Gain code bits 3:0
    localparam int VCP_TXG_LOWPD    = 7;  // Low-power / detector override
    localparam int VCP_TXG_W        = 8;

    // Format fields
    localparam int VCP_FMT_LIN_BIT  = 0;  // 1 = 15-bit linear
    localparam int VCP_FMT_ALAW_BIT = 1;  // 1 = A-law, 0 = mu-law
    localparam int VCP_FMT_W        = 2;

    // Reset values
    localparam logic [7:0] VCP_PWR_RESET = 8'h00;
    localparam logic [7:0] VCP_TXG_RESET = 8'h08;  // Code 1000, 23.5 dB
    localparam logic [1:0] VCP_FMT_RESET = 2'h0;   // Companded, mu-law

    // Sample slot lengths
    localparam logic [4:0] VCP_BITS_LIN = 5'h0F;   // 15
    localparam logic [4:0] VCP_BITS_CMP = 5'h08;   // 8

    // Master clock watchdog time base
    localparam int VCP_CLK_MHZ      = 250;
    localparam int VCP_MCLK_LOSS_NS = 2000;        // Longest tolerated gap
    localparam int VCP_MCLK_LOSS_CYC = (VCP_MCLK_LOSS_NS * VCP_CLK_MHZ) / 1000;
    localparam int VCP_WD_W         = 10;

    // Power sequencing states, one-hot
    typedef enum logic [2:0] {
        VCP_ST_DOWN  = 3'b001,
        VCP_ST_UP    = 3'b010,
        VCP_ST_DRAIN = 3'b100
    } vcp_pwr_type;

endpackage : vcp_pkg

// ===== logic/vcp_codec_ctrl.sv
// Digital control of a voice codec: power sequencing, gain and mute controls,
// sample format selection and the framed serial sample port.
// Assumes an AHB-Lite master on hclk, a converter sample bus on hclk, and
// master clock and serial port pins asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

module vcp_codec_ctrl
    import vcp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        master_clk,
    input  wire logic [14:0] adc_sample,
    input  wire logic        serial_bit_clock,
    input  wire logic        frame_sync,
    input  wire logic        serial_rx_in,
    output logic             serial_tx_out,
    output logic             serial_tx_oe,
    output logic [14:0]      rx_sample,
    output logic             rx_sample_valid,
    output logic             powered_up,
    output logic             low_power_down,
    output logic             differential_earpiece_amp,
    output logic             single_ended_earpiece_amp,
    output logic             microphone_silence,
    output logic [3:0]       tx_gain_code,
    output logic             second_mic_stage_en,
    output logic [2:0]       transmit_gain_stage
);

    localparam logic [VCP_WD_W-1:0] WD_LIMIT = VCP_WD_W'(VCP_MCLK_LOSS_CYC);

    // Mu-law or A-law encode of a two's-complement linear sample
    function automatic logic [7:0] vcp_compand(input logic [14:0] x, input logic alaw);
        logic        sgn;
        logic [13:0] mag;
        logic [13:0] v;
        logic [13:0] sh;
        logic [2:0]  seg;
        logic [7:0]  c;
        sgn = x[14];
        // Ones-complement magnitude; the half-step error is within the law's tolerance
        mag = sgn ? ~x[13:0] : x[13:0];
        seg = 3'h0;
        if (alaw) begin
            v = {2'h0, mag[13:2]};
            for (int i = 1; i < 8; i++) begin
                if (v[i+4]) seg = 3'(i);
            end
            sh = (seg == 3'h0) ? (v >> 1) : (v >> seg);
            c = {~sgn, seg, sh[3:0]} ^ 8'h55;
        end else begin
            v = {1'b0, mag[13:1]} + 14'h0021;
            if (v[13]) v = 14'h1FFF;  // Clip above top segment
            for (int i = 0; i < 8; i++) begin
                if (v[i+5]) seg = 3'(i);
            end
            sh = v >> ({1'b0, seg} + 4'h1);  // Four bits wide: segment 7 shifts by 8
            c = {~sgn, ~seg, ~sh[3:0]};
        end
        return c;
    endfunction : vcp_compand

    // ---------------- Register bus ----------------
    logic [7:0]  pwr_q, pwr_d;          // Power control
    logic [7:0]  txg_q, txg_d;          // Transmit gain
    logic [1:0]  fmt_q, fmt_d;          // Format
    logic        wr_q, wr_d;            // Pending write data phase
    logic        rd_q, rd_d;            // Pending read data phase
    logic [7:0]  addr_q, addr_d;        // Latched byte offset
    logic        clk_ok_q;              // Master clock present
    vcp_pwr_type state_q;               // Power state
    logic [4:0]  bit_cnt_q;             // Bits shifted in current sample
    logic [14:0] rx_word_q;             // Last complete received word

    // Address phase capture and register writes
    always_comb begin
        logic take;
        take   = hsel && hready && htrans[1];
        wr_d   = take && hwrite;
        rd_d   = take && !hwrite;
        addr_d = take ? haddr[7:0] : addr_q;
        pwr_d  = pwr_q;
        txg_d  = txg_q;
        fmt_d  = fmt_q;
        // Writes land whatever the power state
        if (wr_q) begin
            case (addr_q)
                VCP_OFS_POWER:  pwr_d = hwdata[7:0];
                VCP_OFS_TXGAIN: txg_d = hwdata[7:0];
                VCP_OFS_FORMAT: fmt_d = hwdata[1:0];
                default:        ;  // Unmapped or read-only: ignored
            endcase
        end
    end

    // Register bus state; reset loads the defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_q  <= VCP_PWR_RESET;
            txg_q  <= VCP_TXG_RESET;
            fmt_q  <= VCP_FMT_RESET;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            pwr_q  <= pwr_d;
            txg_q  <= txg_d;
            fmt_q  <= fmt_d;
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            addr_q <= addr_d;
        end
    end

    // Read mux from register outputs; unmapped offsets read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_q) begin
            case (addr_q)
                VCP_OFS_POWER:  hrdata = {24'h000000, pwr_q};
                VCP_OFS_TXGAIN: hrdata = {24'h000000, txg_q};
                VCP_OFS_FORMAT: hrdata = {30'h00000000, fmt_q};
                VCP_OFS_STATUS: hrdata = {24'h000000, bit_cnt_q, state_q == VCP_ST_DRAIN,
                                          clk_ok_q, state_q != VCP_ST_DOWN};
                VCP_OFS_RXDATA: hrdata = {17'h00000, rx_word_q};
                default:        hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ---------------- Master clock watchdog ----------------
    logic                mclk_s1_q, mclk_s2_q, mclk_s3_q;  // Synchroniser and history
    logic [VCP_WD_W-1:0] wd_q, wd_d;                       // Cycles since last edge
    logic                clk_ok_d;

    // Any master clock edge restarts the count; reaching the limit means loss
    always_comb begin
        wd_d     = wd_q;
        clk_ok_d = clk_ok_q;
        if (mclk_s2_q != mclk_s3_q) begin
            wd_d     = '0;
            clk_ok_d = 1'b1;
        end else if (wd_q >= WD_LIMIT - 1'b1) begin
            clk_ok_d = 1'b0;
        end else begin
            wd_d = wd_q + 1'b1;
        end
    end

    // Watchdog registers; no clock is assumed present until an edge is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_s3_q <= 1'b0;
            wd_q      <= '0;
            clk_ok_q  <= 1'b0;
        end else begin
            mclk_s1_q <= master_clk;
            mclk_s2_q <= mclk_s1_q;
            mclk_s3_q <= mclk_s2_q;
            wd_q      <= wd_d;
            clk_ok_q  <= clk_ok_d;
        end
    end

    // ---------------- Power sequencing ----------------
    logic        override;      // Detector ignored
    logic        clk_loss_pd;   // Clock-loss power-down
    logic        down_req;      // Any reason to power down
    logic        busy;          // A sample is on the wire
    vcp_pwr_type state_d;

    assign override    = txg_q[VCP_TXG_LOWPD];
    assign clk_loss_pd = !clk_ok_q && !override;
    assign down_req    = !pwr_q[VCP_PWR_ON_BIT] || clk_loss_pd;
    assign busy        = armed_q || bit_cnt_q != 5'h00;  // Armed: first bit still due

    // Power-down is deferred while a sample is still shifting
    always_comb begin
        case (state_q)
            VCP_ST_DOWN:  state_d = down_req ? VCP_ST_DOWN : VCP_ST_UP;
            VCP_ST_UP: begin
                if (!down_req)  state_d = VCP_ST_UP;
                else if (busy)  state_d = VCP_ST_DRAIN;
                else            state_d = VCP_ST_DOWN;
            end
            VCP_ST_DRAIN: state_d = busy ? VCP_ST_DRAIN : VCP_ST_DOWN;
            default:      state_d = VCP_ST_DOWN;
        endcase
    end

    // Power state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= VCP_ST_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // Analog control outputs, all decoded combinationally from registers
    assign powered_up                = state_q != VCP_ST_DOWN;
    // Deeper power-down when bit 7 is set
    assign low_power_down            = !powered_up && txg_q[VCP_TXG_LOWPD];
    assign differential_earpiece_amp = powered_up && pwr_q[VCP_PWR_EAR_BIT];
    assign single_ended_earpiece_amp = powered_up && !pwr_q[VCP_PWR_EAR_BIT];
    assign microphone_silence        = pwr_q[VCP_PWR_MUTE_BIT];
    assign tx_gain_code              = txg_q[VCP_TXG_CODE_MSB:0];
    // Upper code bit low selects the extra 12 dB microphone stage
    assign second_mic_stage_en       = !txg_q[VCP_TXG_CODE_MSB];
    // Programmable stage in -2 dB steps
    assign transmit_gain_stage       = txg_q[2:0];

    // ---------------- Serial sample port ----------------
    logic        bclk_s1_q, bclk_s2_q, bclk_s3_q;  // Bit clock sync and history
    logic        fs_s1_q, fs_s2_q;                 // Frame sync sync
    logic        rxd_s1_q, rxd_s2_q;               // Receive data sync
    logic        bclk_rise, bclk_fall;
    logic [4:0]  bit_cnt_d;
    logic [4:0]  nbits_q, nbits_d;                 // Slot length this frame
    logic [14:0] tx_sh_q, tx_sh_d;                 // Transmit shifter, msb aligned
    logic [14:0] rx_sh_q, rx_sh_d;                 // Receive shifter
    logic [14:0] rx_word_d;
    logic        rx_vld_q, rx_vld_d;
    logic        armed_q, armed_d;                 // Frame seen, first bit pending
    logic        oe_q, oe_d;
    logic        txd_q, txd_d;

    assign bclk_rise = bclk_s2_q && !bclk_s3_q;
    assign bclk_fall = !bclk_s2_q && bclk_s3_q;

    // Frame, shift and capture sequencing
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        nbits_d   = nbits_q;
        tx_sh_d   = tx_sh_q;
        rx_sh_d   = rx_sh_q;
        rx_word_d = rx_word_q;
        rx_vld_d  = 1'b0;
        armed_d   = armed_q;
        oe_d      = oe_q;
        txd_d     = txd_q;
        if (bclk_fall) begin
            if (busy) begin
                // Capture one receive bit, msb first
                rx_sh_d = {rx_sh_q[13:0], rxd_s2_q};
                if (bit_cnt_q == nbits_q) begin
                    // Last bit done: release the line and deliver the word
                    oe_d      = 1'b0;
                    bit_cnt_d = 5'h00;
                    rx_vld_d  = 1'b1;
                    rx_word_d = fmt_q[VCP_FMT_LIN_BIT] ? {rx_sh_q[13:0], rxd_s2_q}
                                                       : {7'h00, rx_sh_q[6:0], rxd_s2_q};
                end
            end else if (fs_s2_q && state_q == VCP_ST_UP) begin
                // Frame start; slot length and transmit sample frozen for the whole slot
                armed_d = 1'b1;
                if (fmt_q[VCP_FMT_LIN_BIT]) begin
                    nbits_d = VCP_BITS_LIN;
                    tx_sh_d = adc_sample;
                end else begin
                    nbits_d = VCP_BITS_CMP;
                    tx_sh_d = {vcp_compand(adc_sample, fmt_q[VCP_FMT_ALAW_BIT]), 7'h00};
                end
            end
        end else if (bclk_rise) begin
            if (armed_q || (busy && bit_cnt_q < nbits_q)) begin
                // Launch next bit, msb first, only inside the slot
                armed_d   = 1'b0;
                oe_d      = 1'b1;
                txd_d     = tx_sh_q[14];
                tx_sh_d   = {tx_sh_q[13:0], 1'b0};
                bit_cnt_d = bit_cnt_q + 5'h01;
            end
        end
    end

    // Serial port registers and pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
            fs_s1_q   <= 1'b0;
            fs_s2_q   <= 1'b0;
            rxd_s1_q  <= 1'b0;
            rxd_s2_q  <= 1'b0;
            bit_cnt_q <= 5'h00;
            nbits_q   <= VCP_BITS_CMP;
            tx_sh_q   <= 15'h0000;
            rx_sh_q   <= 15'h0000;
            rx_word_q <= 15'h0000;
            rx_vld_q  <= 1'b0;
            armed_q   <= 1'b0;
            oe_q      <= 1'b0;
            txd_q     <= 1'b0;
        end else begin
            bclk_s1_q <= serial_bit_clock;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
            fs_s1_q   <= frame_sync;
            fs_s2_q   <= fs_s1_q;
            rxd_s1_q  <= serial_rx_in;
            rxd_s2_q  <= rxd_s1_q;
            bit_cnt_q <= bit_cnt_d;
            nbits_q   <= nbits_d;
            tx_sh_q   <= tx_sh_d;
            rx_sh_q   <= rx_sh_d;
            rx_word_q <= rx_word_d;
            rx_vld_q  <= rx_vld_d;
            armed_q   <= armed_d;
            oe_q      <= oe_d;
            txd_q     <= txd_d;
        end
    end

    // Losing the master clock floats the line at once, even mid-sample, unless gain bit 7 overrides the detector
    assign serial_tx_oe    = oe_q && !clk_loss_pd;
    assign serial_tx_out   = txd_q;
    assign rx_sample       = rx_word_q;
    assign rx_sample_valid = rx_vld_q;

    // ---------------- Checks ----------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_pd_idle;
        (state_q == VCP_ST_UP && !pwr_q[VCP_PWR_ON_BIT] && !busy) |=> state_q == VCP_ST_DOWN;
    endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("power-down not taken");

    property p_drain;
        (state_q != VCP_ST_DOWN && busy) |=> state_q != VCP_ST_DOWN;
    endproperty
    a_drain: assert property (p_drain) else $error("powered down mid-sample");

    property p_clk_loss;
        (!clk_ok_q && !override && !busy) |=> state_q == VCP_ST_DOWN;
    endproperty
    a_clk_loss: assert property (p_clk_loss) else $error("clock loss kept power");

    property p_float;
        (!clk_ok_d && !override) |=> (!serial_tx_oe || override);
    endproperty
    a_float: assert property (p_float) else $error("line driven without clock");

    property p_mute;
        (wr_q && addr_q == VCP_OFS_POWER) |=> microphone_silence == $past(hwdata[6]);
    endproperty
    a_mute: assert property (p_mute) else $error("mute not written");

    property p_gain;
        (wr_q && addr_q == VCP_OFS_TXGAIN) |=>
            (tx_gain_code == $past(hwdata[3:0])) && (second_mic_stage_en == !$past(hwdata[3]));
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not applied");

    property p_launch;
        $rose(oe_q) |-> $past(bclk_rise);
    endproperty
    a_launch: assert property (p_launch) else $error("drive began off rising edge");

    property p_release;
        $fell(oe_q) |-> $past(bclk_fall) && $past(bit_cnt_q) == $past(nbits_q);
    endproperty
    a_release: assert property (p_release) else $error("release not after last bit");

    property p_slot;
        oe_q |-> (bit_cnt_q != 5'h00) && (bit_cnt_q <= nbits_q);
    endproperty
    a_slot: assert property (p_slot) else $error("driven outside sample slot");

    property p_ear;
        (state_q == VCP_ST_UP) |->
            differential_earpiece_amp == pwr_q[1] && single_ended_earpiece_amp == !pwr_q[1];
    endproperty
    a_ear: assert property (p_ear) else $error("earpiece select wrong");

endmodule : vcp_codec_ctrl

`default_nettype wire

// ===== testbench/vcp_pcm_partner.sv
// Far-side serial port model: bit clock, frame sync and receive data.
// Assumes run is raised by the bench; the clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none

module vcp_pcm_partner (
    input  wire logic        run,
    input  wire logic        lin,
    input  wire logic [14:0] word,
    output logic             bclk,
    output logic             fsync,
    output logic             rxd
);
    int nb;  // Bits in one sample

    // One frame per pass; a 1 ns skew keeps edges off hclk edges
    initial begin
        bclk  = 1'b0;
        fsync = 1'b0;
        rxd   = 1'b0;
        forever begin
            wait (run === 1'b1);
            #1;
            nb = lin ? 15 : 8;
            for (int i = 0; i < 256; i++) begin
                bclk = 1'b1;
                #4;
                fsync = (i == 0);
                // Slot bits msb first, a toggling filler elsewhere
                rxd = (i >= 1 && i <= nb) ? word[nb - i] : ~rxd;
                #20 bclk = 1'b0;
                #24;
            end
            fsync = 1'b0;
        end
    end
endmodule : vcp_pcm_partner
`default_nettype wire

// ===== testbench/vcp_codec_ctrl_tb.sv
// Bench: register access, power sequencing and serial frames.
// Assumes the partner model drives the serial pins and hready is hreadyout.
`timescale 1ns/1ps
`default_nettype none

module vcp_codec_ctrl_tb;
    import vcp_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, transmit_gain_stage;
    logic [14:0] adc_sample, word, rx_sample, rx_got;
    logic [3:0]  tx_gain_code;
    logic        master_clk, mclk_on, run, lin, exp_oe;
    logic        serial_bit_clock, frame_sync, serial_rx_in;
    logic        serial_tx_out, serial_tx_oe, rx_sample_valid, powered_up;
    logic        low_power_down, differential_earpiece_amp, second_mic_stage_en;
    logic        single_ended_earpiece_amp, microphone_silence;
    logic [7:0]  cmp_code;  // Expected companded code of adc_sample
    int          n_fail, checked, mcnt, slot, nb;

    vcp_codec_ctrl u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .master_clk,
        .adc_sample, .serial_bit_clock, .frame_sync, .serial_rx_in,
        .serial_tx_out, .serial_tx_oe, .rx_sample, .rx_sample_valid,
        .powered_up, .low_power_down, .differential_earpiece_amp,
        .single_ended_earpiece_amp, .microphone_silence, .tx_gain_code,
        .second_mic_stage_en, .transmit_gain_stage
    );

    vcp_pcm_partner u_far (
        .run, .lin, .word, .bclk(serial_bit_clock), .fsync(frame_sync),
        .rxd(serial_rx_in)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Master clock near 2 MHz, halted to provoke clock loss
    always @(posedge hclk) begin
        mcnt <= (mcnt == 60) ? 0 : mcnt + 1;
        if (mcnt == 60 && mclk_on)
            master_clk <= ~master_clk;
    end

    // Keep the last received word
    always @(posedge hclk) begin
        if (rx_sample_valid === 1'b1)
            rx_got <= rx_sample;
    end

    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Transmit pin watched at every falling bit clock edge once out of reset
    always @(negedge serial_bit_clock) begin
        if (hresetn === 1'b1) begin
            slot = frame_sync ? 0 : slot + 1;
            nb = lin ? 15 : 8;
            chk("tx_oe", exp_oe && slot >= 1 && slot <= nb, serial_tx_oe);
            if (exp_oe && lin && slot >= 1 && slot <= nb)
                chk("tx_bit", adc_sample[15 - slot], serial_tx_out);
            else if (exp_oe && slot >= 1 && slot <= nb)
                chk("tx_code", cmp_code[8 - slot], serial_tx_out);
        end
    end

    // Bounded wait on the bus handshake
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_fail++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy

    // One single transfer; read data is taken at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (2) @(posedge hclk);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk

    task automatic wait_pwr(input logic v);
        int n;
        n = 0;
        while (powered_up !== v && n < 300) begin
            @(posedge hclk);
            n++;
        end
        chk("powered", v, powered_up);
        if (n >= 300)
            report_and_stop();
    endtask : wait_pwr

    task automatic frame_go(input logic [14:0] w);
        word <= w;
        run  <= 1'b1;
        repeat (20) @(posedge hclk);
        run  <= 1'b0;
    endtask : frame_go

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, run, lin, exp_oe} = '0;
        {master_clk, word, n_fail, checked, mcnt} = '0;
        hsize = 3'h2;
        mclk_on = 1'b1;
        adc_sample = 15'h5A3C;
        slot = 300;
        repeat (125) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("gain_code", 32'h8, tx_gain_code);
        chk("second_stage", 32'h0, second_mic_stage_en);
        chk("powered", 32'h0, powered_up);
        chk("hresp", 32'h0, hresp);
        rchk("power", VCP_OFS_POWER, 32'h0);
        rchk("txgain", VCP_OFS_TXGAIN, 32'h8);
        rchk("format", VCP_OFS_FORMAT, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        // Every listed gain code, written while still powered down
        for (int c = 0; c < 14; c++) begin
            if (c < 6 || c > 7) begin
                wr(VCP_OFS_TXGAIN, c);
                chk("gain_code", c, tx_gain_code);
                chk("second_stage", c < 8, second_mic_stage_en);
                chk("pga_step", c % 8, transmit_gain_stage);
            end
        end
        rchk("txgain", VCP_OFS_TXGAIN, 32'hD);
        frame_go(15'h0101);
        repeat (3100) @(posedge hclk);
        wr(VCP_OFS_TXGAIN, 32'h08);
        wr(VCP_OFS_FORMAT, 32'h1);
        lin = 1'b1;
        wr(VCP_OFS_POWER, 32'h43);
        wait_pwr(1'b1);
        rchk("status", VCP_OFS_STATUS, 32'h3);
        chk("diff_ear", 32'h1, differential_earpiece_amp);
        chk("single_ear", 32'h0, single_ended_earpiece_amp);
        chk("mute", 32'h1, microphone_silence);
        wr(VCP_OFS_POWER, 32'h01);
        chk("single_ear", 32'h1, single_ended_earpiece_amp);
        chk("mute", 32'h0, microphone_silence);
        exp_oe = 1'b1;
        // Linear frame, then both companding laws
        for (int f = 0; f < 3; f++) begin
            wr(VCP_OFS_FORMAT, (f == 0) ? 1 : 2 * (f - 1));
            lin = (f == 0);
            cmp_code = (f == 2) ? 8'h27 : 8'h0C;
            frame_go(15'h2D71 + f);
            repeat (3100) @(posedge hclk);
            chk("rx_word", lin ? 15'h2D71 : 15'h71 + f, rx_got);
        end
        rchk("rxdata", VCP_OFS_RXDATA, 32'h73);
        // Power-down request in mid-sample
        wr(VCP_OFS_FORMAT, 32'h1);
        lin = 1'b1;
        frame_go(15'h3C0F);
        repeat (60) @(posedge hclk);
        wr(VCP_OFS_POWER, 32'h00);
        chk("powered", 32'h1, powered_up);
        repeat (3040) @(posedge hclk);
        chk("rx_word", 15'h3C0F, rx_got);
        wait_pwr(1'b0);
        chk("low_pd", 32'h0, low_power_down);
        exp_oe = 1'b0;
        // Clock loss forces power-down, then recovery
        wr(VCP_OFS_POWER, 32'h01);
        wait_pwr(1'b1);
        mclk_on <= 1'b0;
        repeat (600) @(posedge hclk);
        chk("powered", 32'h0, powered_up);
        chk("tx_oe", 32'h0, serial_tx_oe);
        mclk_on <= 1'b1;
        wr(VCP_OFS_POWER, 32'h01);
        wait_pwr(1'b1);
        // Detector override keeps power through a clock loss
        wr(VCP_OFS_TXGAIN, 32'h88);
        mclk_on <= 1'b0;
        repeat (600) @(posedge hclk);
        chk("powered", 32'h1, powered_up);
        wr(VCP_OFS_POWER, 32'h00);
        wait_pwr(1'b0);
        chk("low_pd", 32'h1, low_power_down);
        report_and_stop();
    end
endmodule : vcp_codec_ctrl_tb
`default_nettype wire
